// ---- verilog/fcl_pkg.sv ----
// Package with register map, field layout and timing constants of the fuse loader.
package fcl_pkg;
  localparam logic [7:0] FCL_OFS_BROWNOUT = 8'h01;
  localparam logic [7:0] FCL_OFS_OSCILLATOR = 8'h02;
  localparam logic [7:0] FCL_OFS_TIMER = 8'h04;
  localparam logic [7:0] FCL_OFS_SYS_ZERO = 8'h05;
  localparam logic [7:0] FCL_OFS_SYS_ONE = 8'h06;
  localparam logic [7:0] FCL_OFS_APP_END = 8'h07;
  localparam logic [7:0] FCL_OFS_BOOT_END = 8'h08;
  localparam logic [7:0] FCL_OFS_STATUS = 8'h10;
  localparam logic [7:0] FCL_SYS_ZERO_RESET = 8'hC4;
  localparam logic [7:0] FCL_OSC_RESET = 8'h02;
  localparam logic [7:0] FCL_SYS_ONE_RESET = 8'h07;
  localparam logic [7:0] FCL_ZERO_BYTE = 8'h00;
  localparam logic [1:0] FCL_PIN_GPIO = 2'h0;
  localparam logic [1:0] FCL_CRC_OFF = 2'h3;
  localparam int FCL_SLOW_CYCLES = 768;
  localparam int FCL_SLOW_HZ = 32768;
  localparam int FCL_CLK_HZ = 10000000;
  // The product overflows a 32-bit int, so the rounding is worked out in 64 bits.
  localparam longint FCL_HOLD_CYCLES_I =
    (longint'(FCL_SLOW_CYCLES) * FCL_CLK_HZ + FCL_SLOW_HZ - 1) / FCL_SLOW_HZ;
  localparam logic [17:0] FCL_HOLD_CYCLES = FCL_HOLD_CYCLES_I[17:0];
  localparam logic [2:0] FCL_NUM_FUSES = 3'h7;

  typedef enum logic [1:0] {
    FCL_IDLE = 2'b00,
    FCL_LOAD = 2'b01,
    FCL_DONE = 2'b10
  } fcl_state_t;

  typedef struct packed {
    logic [2:0] detector_threshold_code;
    logic detector_sample_rate;
    logic [1:0] awake_mode;
    logic [1:0] sleep_mode;
  } fcl_brownout_t;

  typedef struct packed {
    logic calibration_lock;
    logic [1:0] oscillator_frequency_choice;
    logic [7:0] timer_fault_control;
    logic [1:0] checksum_scan_region;
    logic checksum_scan_off;
    logic [1:0] reset_pin_function;
    logic keep_eeprom_on_erase;
    logic [2:0] startup_delay_code;
    logic [7:0] application_end_block;
    logic [7:0] boot_end_block;
    logic whole_flash_boot;
  } fcl_config_t;
endpackage : fcl_pkg

// ---- verilog/fcl_loader.sv ----
// Fuse configuration loader: copies fuse bytes into unit controls at reset.
// Operation
// - Detector reloads only after power-on reset.
// - Fuse bits 7:5 give detector threshold.
// - Fuse bit 4 gives detector sample rate.
// - Fuse bits 3:2 give awake detector mode.
// - Fuse bits 1:0 give sleep mode.
// - Oscillator bit 7 locks calibration registers.
// - Oscillator bits 1:0 select frequency.
// - Timer fuse byte copies into fault control.
// - Timer compare fields reload on power-on only.
// - Timer bits 7:4 enable compare pins.
// - Timer bits 3:0 give default levels.
// - System bits 7:6 choose checksum region.
// - System bits 3:2 choose reset pin function.
// - GPIO reset pin driver off 768 slow cycles.
// - System bit 0 keeps EEPROM unless locked.
// - Second system bits 2:0 select startup delay.
// - Application end marks code in 256-byte blocks.
// - Both ends zero means all flash boot.
// - Flash above application end is data; while boot end is zero the code makes all flash boot.
// - Boot end gives boot size in blocks.
//
// Implementation choice: the strobed register port.
module fcl_loader (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on_reset,
  input wire logic [7:0] fuse_rd_data,
  output logic [2:0] fuse_index,
  input wire logic device_locked,
  input wire logic [7:0] flash_block,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output fcl_pkg::fcl_brownout_t brownout_ctrl,
  output fcl_pkg::fcl_config_t sys_ctrl,
  output logic erase_keeps_eeprom,
  output logic [1:0] flash_class,
  output logic reset_pin_drive_allowed,
  output logic units_released
);
  import fcl_pkg::*;

  fcl_state_t state_r, state_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic por_seen_r, por_seen_nxt;
  logic [7:0] fuse_r [0:7];
  logic [7:0] fuse_nxt [0:7];
  logic [17:0] hold_r, hold_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] bo_copy_r, bo_copy_nxt;
  logic [7:0] tm_copy_r, tm_copy_nxt;

  // Software sees the raw fuse bytes, refetched on every reset; the detector and timer
  // copies further down are gated on power-on separately.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    por_seen_nxt = por_seen_r;
    for (int i = 0; i < 8; i++) begin
      fuse_nxt[i] = fuse_r[i];
    end
    case (state_r)
      FCL_IDLE: begin
        por_seen_nxt = power_on_reset;
        idx_nxt = 3'h1;
        state_nxt = FCL_LOAD;
      end
      FCL_LOAD: begin
        fuse_nxt[idx_r] = fuse_rd_data;
        if (idx_r == FCL_OFS_BOOT_END[2:0]) begin
          state_nxt = FCL_DONE;
        end else begin
          idx_nxt = 3'(idx_r + 3'h1);
        end
      end
      FCL_DONE: begin
        state_nxt = FCL_DONE;
      end
      default: begin
        state_nxt = FCL_IDLE;
      end
    endcase
  end

  assign fuse_index = idx_r;

  // The copies carry no reset: the detector and timer keep their settings through warm
  // resets, so only a load that follows a power-on reset may refresh them.
  always_comb begin
    bo_copy_nxt = bo_copy_r;
    tm_copy_nxt = tm_copy_r;
    if (state_r == FCL_LOAD && por_seen_r && idx_r == FCL_OFS_BROWNOUT[2:0]) begin
      bo_copy_nxt = fuse_rd_data;
    end
    if (state_r == FCL_LOAD && por_seen_r && idx_r == FCL_OFS_TIMER[2:0]) begin
      tm_copy_nxt = fuse_rd_data;
    end
  end

  // The copies are unknown until the first power-on load has run.
  always_ff @(posedge clk) begin
    bo_copy_r <= bo_copy_nxt;
    tm_copy_r <= tm_copy_nxt;
  end

  assign units_released = (state_r == FCL_DONE);

  always_comb begin
    hold_nxt = hold_r;
    if (state_r == FCL_DONE && hold_r != FCL_HOLD_CYCLES) begin
      hold_nxt = 18'(hold_r + 18'h1);
    end
  end
  assign reset_pin_drive_allowed = units_released &&
    (sys_ctrl.reset_pin_function != FCL_PIN_GPIO || hold_r == FCL_HOLD_CYCLES);

  // Fuse bytes are read only; writes are ignored and unmapped reads return zero.
  always_comb begin
    rdata_nxt = FCL_ZERO_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        FCL_OFS_BROWNOUT: rdata_nxt = fuse_r[1];
        FCL_OFS_OSCILLATOR: rdata_nxt = fuse_r[2];
        FCL_OFS_TIMER: rdata_nxt = fuse_r[4];
        FCL_OFS_SYS_ZERO: rdata_nxt = fuse_r[5];
        FCL_OFS_SYS_ONE: rdata_nxt = fuse_r[6];
        FCL_OFS_APP_END: rdata_nxt = fuse_r[7];
        FCL_OFS_BOOT_END: rdata_nxt = fuse_r[0];
        FCL_OFS_STATUS: rdata_nxt = {6'h00, reset_pin_drive_allowed, units_released};
        default: rdata_nxt = FCL_ZERO_BYTE;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= FCL_IDLE;
      idx_r <= 3'h0;
      por_seen_r <= 1'b0;
      hold_r <= 18'h0;
      rdata_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        fuse_r[i] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      por_seen_r <= por_seen_nxt;
      hold_r <= hold_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < 8; i++) begin
        fuse_r[i] <= fuse_nxt[i];
      end
    end
  end

  assign brownout_ctrl.detector_threshold_code = bo_copy_r[7:5];
  assign brownout_ctrl.detector_sample_rate = bo_copy_r[4];
  assign brownout_ctrl.awake_mode = bo_copy_r[3:2];
  assign brownout_ctrl.sleep_mode = bo_copy_r[1:0];
  assign sys_ctrl.calibration_lock = fuse_r[2][7];
  assign sys_ctrl.oscillator_frequency_choice = fuse_r[2][1:0];
  assign sys_ctrl.timer_fault_control = tm_copy_r;
  assign sys_ctrl.checksum_scan_region = fuse_r[5][7:6];
  assign sys_ctrl.checksum_scan_off = (fuse_r[5][7:6] == FCL_CRC_OFF);
  assign sys_ctrl.reset_pin_function = fuse_r[5][3:2];
  assign sys_ctrl.keep_eeprom_on_erase = fuse_r[5][0];
  assign erase_keeps_eeprom = fuse_r[5][0] && !device_locked;
  assign sys_ctrl.startup_delay_code = fuse_r[6][2:0];
  assign sys_ctrl.application_end_block = fuse_r[7];
  assign sys_ctrl.boot_end_block = fuse_r[0];
  assign sys_ctrl.whole_flash_boot = (fuse_r[7] == FCL_ZERO_BYTE) && (fuse_r[0] == FCL_ZERO_BYTE);

  always_comb begin
    if (fuse_r[0] == FCL_ZERO_BYTE || flash_block < fuse_r[0]) begin
      flash_class = 2'h0;
    end else if (fuse_r[7] == FCL_ZERO_BYTE || flash_block < fuse_r[7]) begin
      flash_class = 2'h1;
    end else begin
      flash_class = 2'h2;
    end
  end

  chk_release_after_load: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(units_released) |-> $past(state_r) == FCL_LOAD &&
    $past(idx_r) == FCL_OFS_BOOT_END[2:0])
    else $error("Units released before all fuses loaded.");
  chk_threshold_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> brownout_ctrl.detector_threshold_code == fuse_r[1][7:5])
    else $error("Threshold does not follow fuse.");
  chk_warm_keeps_detector: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == FCL_LOAD && !por_seen_r |=> bo_copy_r == $past(bo_copy_r))
    else $error("Detector reloaded without power-on.");
  chk_warm_keeps_timer: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == FCL_LOAD && !por_seen_r |=> tm_copy_r == $past(tm_copy_r))
    else $error("Timer reloaded without power-on.");
  chk_gpio_hold_off: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && sys_ctrl.reset_pin_function == FCL_PIN_GPIO && hold_r < FCL_HOLD_CYCLES
    |-> !reset_pin_drive_allowed)
    else $error("Reset pin driven during hold.");
  chk_eeprom_locked: assert property (@(posedge clk) disable iff (!reset_n)
    device_locked |-> !erase_keeps_eeprom)
    else $error("Locked part keeps EEPROM.");
  chk_both_zero_boot: assert property (@(posedge clk) disable iff (!reset_n)
    sys_ctrl.whole_flash_boot |-> flash_class == 2'h0)
    else $error("Whole flash not boot.");
  chk_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == FCL_OFS_APP_END |=> reg_rdata == $past(fuse_r[7]))
    else $error("Application end read wrong.");

  chk_rate_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> brownout_ctrl.detector_sample_rate == fuse_r[1][4])
    else $error("Sample rate does not follow fuse.");

  chk_awake_mode: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> brownout_ctrl.awake_mode == fuse_r[1][3:2])
    else $error("Awake mode does not follow fuse.");

  chk_sleep_mode: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> brownout_ctrl.sleep_mode == fuse_r[1][1:0])
    else $error("Sleep mode does not follow fuse.");

  chk_lock_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.calibration_lock == fuse_r[2][7])
    else $error("Calibration lock does not follow fuse.");

  chk_freq_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.oscillator_frequency_choice == fuse_r[2][1:0])
    else $error("Frequency choice does not follow fuse.");

  chk_fault_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> sys_ctrl.timer_fault_control == fuse_r[4])
    else $error("Fault control does not follow fuse.");

  chk_pin_enables: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> sys_ctrl.timer_fault_control[7:4] == fuse_r[4][7:4])
    else $error("Compare pin enables wrong.");

  chk_default_levels: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && por_seen_r |-> sys_ctrl.timer_fault_control[3:0] == fuse_r[4][3:0])
    else $error("Compare default levels wrong.");

  chk_scan_region: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.checksum_scan_region == fuse_r[5][7:6])
    else $error("Checksum region does not follow fuse.");

  chk_scan_off: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.checksum_scan_off == (fuse_r[5][7:6] == FCL_CRC_OFF))
    else $error("Checksum off decode wrong.");

  chk_pin_function: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.reset_pin_function == fuse_r[5][3:2])
    else $error("Reset pin function does not follow fuse.");

  chk_pin_other_drive: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && sys_ctrl.reset_pin_function != FCL_PIN_GPIO |-> reset_pin_drive_allowed)
    else $error("Non-GPIO reset pin held off.");

  chk_held_in_load: assert property (@(posedge clk) disable iff (!reset_n)
    !units_released |-> !reset_pin_drive_allowed)
    else $error("Pin driven before load finished.");

  chk_hold_saturates: assert property (@(posedge clk) disable iff (!reset_n)
    hold_r == FCL_HOLD_CYCLES |=> hold_r == FCL_HOLD_CYCLES)
    else $error("Hold counter left its end value.");

  chk_eeprom_open: assert property (@(posedge clk) disable iff (!reset_n)
    !device_locked |-> erase_keeps_eeprom == sys_ctrl.keep_eeprom_on_erase)
    else $error("Open part ignores keep bit.");

  chk_startup_code: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.startup_delay_code == fuse_r[6][2:0])
    else $error("Startup delay does not follow fuse.");

  chk_app_end_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.application_end_block == fuse_r[7])
    else $error("Application end does not follow fuse.");

  chk_boot_end_copy: assert property (@(posedge clk) disable iff (!reset_n)
    units_released |-> sys_ctrl.boot_end_block == fuse_r[0])
    else $error("Boot end does not follow fuse.");

  chk_data_above_end: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && fuse_r[0] != FCL_ZERO_BYTE && fuse_r[7] != FCL_ZERO_BYTE &&
    flash_block >= fuse_r[0] && flash_block >= fuse_r[7] |-> flash_class == 2'h2)
    else $error("Block above application end not data.");

  chk_boot_below_end: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && fuse_r[0] != FCL_ZERO_BYTE && flash_block < fuse_r[0]
    |-> flash_class == 2'h0)
    else $error("Block below boot end not boot.");

  chk_code_open_end: assert property (@(posedge clk) disable iff (!reset_n)
    units_released && fuse_r[0] != FCL_ZERO_BYTE && fuse_r[7] == FCL_ZERO_BYTE &&
    flash_block >= fuse_r[0] |-> flash_class == 2'h1)
    else $error("Open application end not code.");

  chk_boot_end_read: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == FCL_OFS_BOOT_END |=> reg_rdata == $past(fuse_r[0]))
    else $error("Boot end read wrong.");

  chk_brownout_read: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == FCL_OFS_BROWNOUT |=> reg_rdata == $past(fuse_r[1]))
    else $error("Brown-out fuse read wrong.");

  chk_sys_one_read: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == FCL_OFS_SYS_ONE |=> reg_rdata == $past(fuse_r[6]))
    else $error("Second system fuse read wrong.");

  chk_index_steps: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == FCL_LOAD && idx_r != FCL_OFS_BOOT_END[2:0]
    |=> state_r == FCL_LOAD && idx_r == 3'($past(idx_r) + 3'h1))
    else $error("Fuse index skipped a byte.");

  cov_power_on_load: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(units_released) && por_seen_r);
  cov_warm_load: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(units_released) && !por_seen_r);
  cov_gpio_release: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_pin_drive_allowed));
  cov_boot_end_read: cover property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == FCL_OFS_BOOT_END);
  cov_data_class: cover property (@(posedge clk) disable iff (!reset_n)
    units_released && flash_class == 2'h2);
endmodule : fcl_loader

// ---- tb/tb_top.sv ----
// Self-checking bench for the fuse configuration loader.
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fcl_pkg::*;
  logic clk, reset_n, power_on_reset, device_locked, reg_wr, reg_rd;
  logic [7:0] flash_block, reg_addr, reg_wdata, reg_rdata, fuse_rd_data;
  logic [2:0] fuse_index;
  logic [1:0] flash_class;
  logic [7:0] fuse_mem [8];
  logic erase_keeps_eeprom, reset_pin_drive_allowed, units_released;
  fcl_brownout_t brownout_ctrl;
  fcl_config_t sys_ctrl;
  int n_mismatch = 0;
  int num_checks = 0;
  // Slot 0 holds the boot end byte, which the loader fetches last, after the application end byte.
  assign fuse_rd_data = fuse_mem[fuse_index];
  fcl_loader uut (.clk(clk), .reset_n(reset_n), .power_on_reset(power_on_reset),
    .fuse_rd_data(fuse_rd_data), .fuse_index(fuse_index), .device_locked(device_locked),
    .flash_block(flash_block), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .brownout_ctrl(brownout_ctrl),
    .sys_ctrl(sys_ctrl), .erase_keeps_eeprom(erase_keeps_eeprom), .flash_class(flash_class),
    .reset_pin_drive_allowed(reset_pin_drive_allowed), .units_released(units_released));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_sim;
    $display("Mismatches %0d, checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task do_reset(input logic por, input logic [7:0] bo, osc, tm, s0, s1, ap, be);
    int n;
    @(posedge clk);
    reset_n <= 1'b0;
    power_on_reset <= por;
    fuse_mem = '{be, bo, osc, 8'h00, tm, s0, s1, ap};
    repeat (5) @(posedge clk);
    `CHK("units_released", 1'b0, units_released)
    reset_n <= 1'b1;
    n = 0;
    while (units_released !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (units_released !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    @(posedge clk);
    power_on_reset <= 1'b0;
  endtask : do_reset
  task rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("reg_rdata", ex, reg_rdata)
  endtask : rd
  task cls(input logic [7:0] blk, input logic lock, input logic [1:0] ex, input logic ek);
    @(posedge clk);
    flash_block <= blk;
    device_locked <= lock;
    @(negedge clk);
    `CHK("flash_class", ex, flash_class)
    `CHK("erase_keeps_eeprom", ek, erase_keeps_eeprom)
  endtask : cls
  task check_cfg(input logic [7:0] bo, osc, tm, s0, s1, ap, be, fb, ft);
    `CHK("brownout_ctrl", bo, brownout_ctrl)
    `CHK("calibration_lock", osc[7], sys_ctrl.calibration_lock)
    `CHK("frequency", osc[1:0], sys_ctrl.oscillator_frequency_choice)
    `CHK("fault_control", tm, sys_ctrl.timer_fault_control)
    `CHK("scan_region", s0[7:6], sys_ctrl.checksum_scan_region)
    `CHK("scan_off", s0[7:6] == FCL_CRC_OFF, sys_ctrl.checksum_scan_off)
    `CHK("pin_function", s0[3:2], sys_ctrl.reset_pin_function)
    `CHK("keep_eeprom", s0[0], sys_ctrl.keep_eeprom_on_erase)
    `CHK("startup_delay", s1[2:0], sys_ctrl.startup_delay_code)
    `CHK("app_end", ap, sys_ctrl.application_end_block)
    `CHK("boot_end", be, sys_ctrl.boot_end_block)
    `CHK("whole_boot", ap == FCL_ZERO_BYTE && be == FCL_ZERO_BYTE, sys_ctrl.whole_flash_boot)
    rd(FCL_OFS_BROWNOUT, fb);
    rd(FCL_OFS_OSCILLATOR, osc);
    rd(FCL_OFS_TIMER, ft);
    rd(FCL_OFS_SYS_ZERO, s0);
    rd(FCL_OFS_SYS_ONE, s1);
    rd(FCL_OFS_APP_END, ap);
    rd(FCL_OFS_BOOT_END, be);
  endtask : check_cfg
  // Power-on load with the pin as GPIO; a write must not disturb a fuse copy.
  task sc_power_on;
    do_reset(1'b1, 8'hE9, 8'h81, 8'hA5, 8'hC1, 8'h05, 8'h10, 8'h08);
    check_cfg(8'hE9, 8'h81, 8'hA5, 8'hC1, 8'h05, 8'h10, 8'h08, 8'hE9, 8'hA5);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= FCL_OFS_BROWNOUT;
    reg_wdata <= 8'h00;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd(FCL_OFS_BROWNOUT, 8'hE9);
    rd(8'h03, 8'h00);
    rd(FCL_OFS_STATUS, 8'h01);
    `CHK("drive_allowed", 1'b0, reset_pin_drive_allowed)
    cls(8'h07, 1'b0, 2'h0, 1'b1);
    cls(8'h0F, 1'b0, 2'h1, 1'b1);
    cls(8'h10, 1'b1, 2'h2, 1'b0);
  endtask : sc_power_on
  // Warm reset: detector and timer copies must survive, other fields reload.
  task sc_warm;
    do_reset(1'b0, 8'h4E, 8'h02, 8'h3C, 8'h48, 8'h07, 8'h00, 8'h00);
    check_cfg(8'hE9, 8'h02, 8'hA5, 8'h48, 8'h07, 8'h00, 8'h00, 8'h4E, 8'h3C);
    `CHK("drive_allowed", 1'b1, reset_pin_drive_allowed)
    cls(8'h80, 1'b0, 2'h0, 1'b0);
  endtask : sc_warm
  initial begin
    reset_n = 1'b0;
    power_on_reset = 1'b1;
    device_locked = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    flash_block = 8'h00;
    fuse_mem = '{default: 8'h00};
    sc_power_on();
    sc_warm();
    end_sim();
  end
endmodule : tb_top
